// ===== rtl/qsr_pkg.sv
// Shared constants and types for the burst-of-four SRAM port model
package qsr_pkg;
   localparam int CLK_MHZ    = 20;
   // DLL lock period in rising edges of the input clock
   localparam int LOCK_CYC   = 2048;
   localparam int DOFF_NS    = 5;
   localparam int KSTOP_NS   = 30;
   localparam int BURST      = 4;
   // Half-edges from command edge to first data beat
   localparam int RD_LAT_HE  = 5;
   localparam int WR_LAT_HE  = 2;

   function automatic int ns_to_cyc_up(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int DOFF_CYC   = ns_to_cyc_up(DOFF_NS);
   localparam int KSTOP_CYC  = ns_to_cyc_up(KSTOP_NS);

   typedef enum logic [1:0] {
      DLL_RESET   = 2'b00,
      DLL_LOCKING = 2'b01,
      DLL_LOCKED  = 2'b11
   } qsr_dll_t;
endpackage

// ===== rtl/qsr_fifo.sv
// Write-beat FIFO with registered read stage
`timescale 1ns/1ps
module qsr_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 16
) (
   input  wire logic         ref_clk_i,
   input  wire logic         resetn_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o,
   output logic              empty_o
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
   logic [AW:0]   cnt, next_cnt;
   logic          next_ov, push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign in_ready_o = (cnt != (AW+1)'(DEPTH));
   assign empty_o    = (cnt == '0) && !out_valid_o;

   always_comb
   begin
      push      = in_valid_i && in_ready_o;
      pop       = (cnt != '0) && (!out_valid_o || out_ready_i);
      next_wptr = push ? bump(wptr) : wptr;
      next_rptr = pop ? bump(rptr) : rptr;
      next_cnt  = cnt + (AW+1)'(push) - (AW+1)'(pop);
      next_ov   = pop || (out_valid_o && !out_ready_i);
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wptr        <= '0;
         rptr        <= '0;
         cnt         <= '0;
         out_valid_o <= 1'b0;
      end
      else
      begin
         wptr        <= next_wptr;
         rptr        <= next_rptr;
         cnt         <= next_cnt;
         out_valid_o <= next_ov;
      end
   end

   // Storage and read stage carry no reset; valid guards them
   always_ff @(posedge ref_clk_i)
   begin
      if (push)
         mem[wptr] <= in_data_i;
      if (pop)
         out_data_o <= mem[rptr];
   end
endmodule // qsr_fifo

// ===== rtl/qsr_top.sv
// Burst-of-four DDR SRAM port: edge capture, DLL lock, forwarding
// Notes on behaviour
// - Each read address yields four beats from the internal burst counter.
// - Each write address takes four beats into successive burst words.
// - Per-beat active-low lane strobes; only strobed lanes are written.
// - A read hitting the write in progress returns the new write beats.
// - Read outputs go disabled one clock after a cycle without a read.
// - DLL-disable low for 5 ns resets the DLL; lock restarts.
// - Input clock static 30 ns or more resets the DLL.
// - Commands at true clock rises; write data at both clock rises.
// - Beats and echo clocks launch from input clock rises; valid aligned.
`timescale 1ns/1ps
module qsr_top import qsr_pkg::*; #(
   parameter int ADDR_W     = 6,
   parameter int DATA_W     = 18,
   parameter int LANES      = 2,
   parameter int FIFO_DEPTH = 16,
   parameter int LOCK_EDGES = LOCK_CYC,
   parameter int STATIC_CYC = KSTOP_CYC
) (
   input  wire logic              ref_clk_i,
   input  wire logic              resetn_i,
   input  wire logic              k_i,
   input  wire logic              k_n_i,
   input  wire logic              read_sel_n_i,
   input  wire logic              write_sel_n_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] data_i,
   input  wire logic [LANES-1:0]  byte_lane_strobe_n_i,
   input  wire logic              dll_off_n_i,
   output logic [DATA_W-1:0]      q_o,
   output logic                   q_oe_n_o,
   output logic                   echo_clock_true_o,
   output logic                   echo_clock_comp_o,
   output logic                   read_valid_flag_o,
   output logic                   dll_locked_o,
   output logic                   buf_ready_o
);
   localparam int LW = DATA_W / LANES;
   localparam int WA = ADDR_W + 2;
   localparam int FW = WA + DATA_W + LANES;
   localparam int PW = 5 + ADDR_W + DATA_W + LANES;
   // k_n and selects idle high in reset, so no false edge at release
   localparam logic [PW-1:0] PIN_RST = {4'b0111, (PW-4)'(0)};

   logic [PW-1:0]     pin_a, pin_s;
   logic              k_s, kn_s, rdn_s, wrn_s, doffn_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic [LANES-1:0]  strb_s;
   logic              k_d, kn_d, krise, hedge, dll_rst;
   qsr_dll_t          dll_state, next_dll;
   logic [15:0]       lock_cnt, next_lock_cnt, stat_cnt, next_stat_cnt;
   logic [3:0]        doff_cnt, next_doff_cnt;
   logic              rp_v, next_rp_v, ra_v, next_ra_v;
   logic              wp_v, next_wp_v, wa_v, next_wa_v;
   logic [2:0]        rp_cnt, next_rp_cnt, wp_cnt, next_wp_cnt;
   logic [1:0]        ra_beat, next_ra_beat, wa_beat, next_wa_beat;
   logic [ADDR_W-1:0] rp_addr, next_rp_addr, ra_addr, next_ra_addr;
   logic [ADDR_W-1:0] wp_addr, next_wp_addr, wa_addr, next_wa_addr;
   logic              fw_v, next_fw_v, fwd_hit;
   logic [ADDR_W-1:0] fw_addr, next_fw_addr;
   logic [BURST-1:0]  fw_have, next_fw_have;
   logic [LANES-1:0]  fw_strb [BURST];
   logic [LANES-1:0]  next_fw_strb [BURST];
   logic [DATA_W-1:0] fw_data [BURST];
   logic [DATA_W-1:0] next_fw_data [BURST];
   logic [LANES-1:0]  fwd_mask;
   logic [DATA_W-1:0] next_q;
   logic              next_oe_n, next_rvalid, next_locked;
   logic [DATA_W-1:0] mem [2**WA];
   logic              f_in_v, f_in_rdy, f_ov, f_empty, drain;
   logic [FW-1:0]     f_in, f_out;
   logic [WA-1:0]     d_addr;
   logic [DATA_W-1:0] d_data;
   logic [LANES-1:0]  d_strb;

   function automatic logic [DATA_W-1:0] lane_merge(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [LANES-1:0]  strb_n);
      logic [DATA_W-1:0] r;
      r = old_w;
      for (int i = 0; i < LANES; i++)
         if (!strb_n[i])
            r[i*LW +: LW] = new_w[i*LW +: LW];
      return r;
   endfunction

   // Whole pin bundle passes two flops; link clock is 8x slower
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pin_a <= PIN_RST;
         pin_s <= PIN_RST;
      end
      else
      begin
         pin_a <= {k_i, k_n_i, read_sel_n_i, write_sel_n_i, dll_off_n_i,
                   addr_i, data_i, byte_lane_strobe_n_i};
         pin_s <= pin_a;
      end
   end

   assign {k_s, kn_s, rdn_s, wrn_s, doffn_s, addr_s, data_s, strb_s} = pin_s;
   assign krise   = k_s && !k_d;
   assign hedge   = krise || (kn_s && !kn_d);
   assign dll_rst = (doff_cnt >= 4'(DOFF_CYC))
                 || (stat_cnt >= 16'(STATIC_CYC));
   assign fwd_hit = fw_v && (fw_addr == ra_addr);
   assign fwd_mask = (fwd_hit && fw_have[ra_beat]) ? fw_strb[ra_beat]
                                                   : '1;
   assign f_in    = {wa_addr, wa_beat, data_s, strb_s};
   assign f_in_v  = hedge && wa_v;
   // Array writes yield to beat launches; lets the FIFO back up
   assign drain   = f_ov && !hedge;
   assign {d_addr, d_data, d_strb} = f_out;

   always_comb
   begin
      next_doff_cnt = doffn_s ? 4'h0
                    : ((doff_cnt == 4'hF) ? doff_cnt : doff_cnt + 4'h1);
      next_stat_cnt = (k_s != k_d) ? 16'h0
                    : ((stat_cnt == 16'hFFFF) ? stat_cnt
                                              : stat_cnt + 16'h1);
      next_dll      = dll_state;
      next_lock_cnt = lock_cnt;
      if (dll_rst)
      begin
         next_dll      = DLL_RESET;
         next_lock_cnt = '0;
      end
      else
         unique case (dll_state)
            DLL_RESET:   next_dll = DLL_LOCKING;
            DLL_LOCKING:
               if (krise)
               begin
                  if (lock_cnt == 16'(LOCK_EDGES - 1))
                     next_dll = DLL_LOCKED;
                  else
                     next_lock_cnt = lock_cnt + 16'h1;
               end
            DLL_LOCKED:  next_dll = DLL_LOCKED;
            default:     next_dll = DLL_RESET;
         endcase
      next_locked = (next_dll == DLL_LOCKED);
   end

   always_comb
   begin
      next_rp_v    = rp_v;
      next_rp_cnt  = rp_cnt;
      next_rp_addr = rp_addr;
      next_ra_v    = ra_v;
      next_ra_beat = ra_beat;
      next_ra_addr = ra_addr;
      next_q       = q_o;
      next_rvalid  = read_valid_flag_o;
      next_oe_n    = q_oe_n_o;
      if (hedge)
      begin
         next_rvalid = 1'b0;
         next_oe_n   = 1'b1;
         if (ra_v)
         begin
            next_q       = lane_merge(mem[{ra_addr, ra_beat}],
                                      fw_data[ra_beat], fwd_mask);
            next_rvalid  = 1'b1;
            next_oe_n    = 1'b0;
            next_ra_beat = ra_beat + 2'd1;
            if (ra_beat == 2'd3)
               next_ra_v = 1'b0;
         end
         if (rp_v)
         begin
            if (rp_cnt == 3'(RD_LAT_HE - 2))
            begin
               next_rp_v    = 1'b0;
               next_ra_v    = 1'b1;
               next_ra_addr = rp_addr;
               next_ra_beat = 2'd0;
            end
            else
               next_rp_cnt = rp_cnt + 3'd1;
         end
         if (krise && !rdn_s)
         begin
            next_rp_v    = 1'b1;
            next_rp_addr = addr_s;
            next_rp_cnt  = 3'd0;
         end
      end
   end

   always_comb
   begin
      next_wp_v    = wp_v;
      next_wp_cnt  = wp_cnt;
      next_wp_addr = wp_addr;
      next_wa_v    = wa_v;
      next_wa_beat = wa_beat;
      next_wa_addr = wa_addr;
      next_fw_v    = fw_v;
      next_fw_addr = fw_addr;
      next_fw_have = fw_have;
      next_fw_data = fw_data;
      next_fw_strb = fw_strb;
      // Forward copy lives until its beats have all left the FIFO
      if (fw_v && (fw_have == '1) && f_empty && !wa_v)
         next_fw_v = 1'b0;
      if (hedge)
      begin
         if (wa_v)
         begin
            next_fw_data[wa_beat] = data_s;
            next_fw_strb[wa_beat] = strb_s;
            next_fw_have[wa_beat] = 1'b1;
            next_wa_beat = wa_beat + 2'd1;
            if (wa_beat == 2'd3)
               next_wa_v = 1'b0;
         end
         if (wp_v)
         begin
            if (wp_cnt == 3'(WR_LAT_HE - 2))
            begin
               next_wp_v    = 1'b0;
               next_wa_v    = 1'b1;
               next_wa_addr = wp_addr;
               next_wa_beat = 2'd0;
               next_fw_v    = 1'b1;
               next_fw_addr = wp_addr;
               next_fw_have = '0;
            end
            else
               next_wp_cnt = wp_cnt + 3'd1;
         end
         if (krise && !wrn_s)
         begin
            next_wp_v    = 1'b1;
            next_wp_addr = addr_s;
            next_wp_cnt  = 3'd0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         k_d <= 1'b0;  kn_d <= 1'b1;
         dll_state <= DLL_RESET;  lock_cnt <= '0;
         stat_cnt <= '0;  doff_cnt <= '0;
         rp_v <= 1'b0;  rp_cnt <= '0;  rp_addr <= '0;
         ra_v <= 1'b0;  ra_beat <= '0;  ra_addr <= '0;
         wp_v <= 1'b0;  wp_cnt <= '0;  wp_addr <= '0;
         wa_v <= 1'b0;  wa_beat <= '0;  wa_addr <= '0;
         fw_v <= 1'b0;  fw_addr <= '0;  fw_have <= '0;
         q_o <= '0;  q_oe_n_o <= 1'b1;  read_valid_flag_o <= 1'b0;
         echo_clock_true_o <= 1'b0;  echo_clock_comp_o <= 1'b0;
         dll_locked_o <= 1'b0;  buf_ready_o <= 1'b0;
      end
      else
      begin
         k_d <= k_s;  kn_d <= kn_s;
         dll_state <= next_dll;  lock_cnt <= next_lock_cnt;
         stat_cnt <= next_stat_cnt;  doff_cnt <= next_doff_cnt;
         rp_v <= next_rp_v;  rp_cnt <= next_rp_cnt;  rp_addr <= next_rp_addr;
         ra_v <= next_ra_v;  ra_beat <= next_ra_beat;  ra_addr <= next_ra_addr;
         wp_v <= next_wp_v;  wp_cnt <= next_wp_cnt;  wp_addr <= next_wp_addr;
         wa_v <= next_wa_v;  wa_beat <= next_wa_beat;  wa_addr <= next_wa_addr;
         fw_v <= next_fw_v;  fw_addr <= next_fw_addr;  fw_have <= next_fw_have;
         q_o <= next_q;  q_oe_n_o <= next_oe_n;
         read_valid_flag_o <= next_rvalid;
         echo_clock_true_o <= k_s;
         echo_clock_comp_o <= kn_s;
         dll_locked_o <= next_locked;  buf_ready_o <= f_in_rdy;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      fw_data <= next_fw_data;
      fw_strb <= next_fw_strb;
      if (drain)
         mem[d_addr] <= lane_merge(mem[d_addr], d_data, d_strb);
   end

   qsr_fifo #(
      .W     (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_wbuf (
      .ref_clk_i   (ref_clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (f_in_v),
      .in_ready_o  (f_in_rdy),
      .in_data_i   (f_in),
      .out_valid_o (f_ov),
      .out_ready_i (!hedge),
      .out_data_o  (f_out),
      .empty_o     (f_empty)
   );

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   a_rd_burst_step: assert property (
      (hedge && ra_v && ra_beat != 2'd3)
      |=> ra_v && ra_beat == $past(ra_beat) + 2'd1)
      else $error("read burst counter did not step");
   a_wr_beat_step: assert property (
      (hedge && wa_v && wa_beat != 2'd3)
      |=> wa_v && wa_beat == $past(wa_beat) + 2'd1)
      else $error("write burst counter did not step");
   a_lane_keep: assert property (
      (drain && d_strb == '1) |=> mem[$past(d_addr)] == $past(mem[d_addr]))
      else $error("unstrobed lanes were written");
   a_fwd_data: assert property (
      (hedge && ra_v && fwd_hit && fw_have[ra_beat]
       && fw_strb[ra_beat] == '0) |=> q_o == $past(fw_data[ra_beat]))
      else $error("write data not forwarded to read");
   a_oe_idle: assert property (
      (hedge && !ra_v) |=> q_oe_n_o && !read_valid_flag_o)
      else $error("outputs still enabled after idle cycle");
   a_lock_wait: assert property (
      (dll_state == DLL_LOCKING && lock_cnt < 16'(LOCK_EDGES - 1))
      |=> !dll_locked_o)
      else $error("DLL reported lock too early");
   a_doff_reset: assert property (
      (doff_cnt >= 4'(DOFF_CYC)) |=> dll_state == DLL_RESET && !dll_locked_o)
      else $error("DLL not reset by disable input");
   a_kstop_reset: assert property (
      (stat_cnt >= 16'(STATIC_CYC)) |=> !dll_locked_o ##1 !dll_locked_o)
      else $error("DLL not reset by static clock");
   a_cmd_on_k: assert property (
      ($rose(rp_v) || $rose(wp_v)) |-> $past(krise))
      else $error("command taken off a true clock rise");
   a_echo_align: assert property (
      ($changed(q_o) || $rose(read_valid_flag_o))
      |-> ($changed(echo_clock_true_o) || $changed(echo_clock_comp_o)))
      else $error("read beat not aligned with echo clock");

   c_read_burst:  cover property ($fell(read_valid_flag_o));
   c_write_burst: cover property (hedge && wa_v && wa_beat == 2'd3);
   c_forward:     cover property (hedge && ra_v && fwd_hit);
   c_locked:      cover property ($rose(dll_locked_o));
endmodule // qsr_top

// ===== verif/qsr_ctrl_model.sv
// Controller model: link clock, commands, write beats and read capture
`timescale 1ns/1ps
module qsr_ctrl_model (
   input  wire logic        ref_clk_i,
   output logic             k_o,
   output logic             k_n_o,
   output logic             read_sel_n_o,
   output logic             write_sel_n_o,
   output logic [5:0]       addr_o,
   output logic [17:0]      data_o,
   output logic [1:0]       strobe_n_o,
   output logic             dll_off_n_o,
   input  wire logic [17:0] q_i,
   input  wire logic        q_oe_n_i,
   input  wire logic        valid_i,
   input  wire logic        echo_true_i
);
   logic [1:0]  tick   = 2'h0;
   logic        run    = 1'b1;
   logic        echo_d = 1'b0;
   logic        oe_bad = 1'b0;
   int          krise  = 0;
   logic [17:0] rx_q [$];

   initial
   begin
      k_o           = 1'b0;
      k_n_o         = 1'b1;
      read_sel_n_o  = 1'b1;
      write_sel_n_o = 1'b1;
      addr_o        = 6'h00;
      data_o        = 18'h00000;
      strobe_n_o    = 2'h3;
      dll_off_n_o   = 1'b1;
   end

   // Four ref cycles a half period; run low stops the clock for DLL tests
   always @(posedge ref_clk_i)
   begin
      if (run)
      begin
         tick <= tick + 2'h1;
         if (tick == 2'h3)
         begin
            k_o   <= ~k_o;
            k_n_o <= k_o;
            if (!k_o)
               krise <= krise + 1;
         end
      end
   end

   // Beats taken on echo edges only while flagged valid
   always @(posedge ref_clk_i)
   begin
      echo_d <= echo_true_i;
      if (valid_i === 1'b1 && echo_true_i !== echo_d)
         rx_q.push_back(q_i);
      if (valid_i === 1'b1 && q_oe_n_i !== 1'b0)
         oe_bad <= 1'b1;
   end

   // Returns at the ref edge where the link clock toggles
   task automatic half();
      int i;
      for (i = 0; i < 8; i++)
      begin
         @(posedge ref_clk_i);
         if (tick == 2'h3)
            break;
      end
   endtask

   task automatic burst(input logic rd, input logic wr, input logic [5:0] a,
                        input logic [17:0] d [4], input logic [1:0] s [4]);
      int h;
      logic bt;
      half();
      if (k_o !== 1'b0)
         half();
      read_sel_n_o  <= ~rd;
      write_sel_n_o <= ~wr;
      addr_o        <= a;
      for (h = 1; h < 7; h++)
      begin
         half();
         read_sel_n_o  <= 1'b1;
         write_sel_n_o <= 1'b1;
         // Released lines toggle so a stale value never looks valid
         addr_o        <= ~a;
         bt = (h >= 2 && h <= 5 && wr);
         data_o        <= bt ? d[h-2] : ~data_o;
         strobe_n_o    <= bt ? s[h-2] : ~strobe_n_o;
      end
   endtask

   task automatic dll_disable();
      dll_off_n_o <= 1'b0;
      @(posedge ref_clk_i);
      dll_off_n_o <= 1'b1;
   endtask
endmodule // qsr_ctrl_model

// ===== verif/tb.sv
// Self-checking bench for the burst-of-four SRAM port and its FIFO
`timescale 1ns/1ps
module tb import qsr_pkg::*; ;
   localparam int LOCK_N = 8;
   logic        ref_clk_i = 1'b0;
   logic        resetn_i  = 1'b0;
   logic        k, k_n, rd_n, wr_n, dll_off_n, q_oe_n, echo_t, rvalid;
   logic        locked, buf_rdy, echo_c;
   logic [5:0]  addr;
   logic [17:0] data, q;
   logic [1:0]  strb;
   logic [17:0] shadow [64][4];
   logic [17:0] wd [4];
   logic [1:0]  ws [4];
   int          num_errors = 0;
   int          n_tests    = 0;
   int          k0;

   always #25 ref_clk_i = ~ref_clk_i;

   qsr_ctrl_model ctrl (.ref_clk_i(ref_clk_i), .k_o(k), .k_n_o(k_n),
      .read_sel_n_o(rd_n), .write_sel_n_o(wr_n), .addr_o(addr),
      .data_o(data), .strobe_n_o(strb), .dll_off_n_o(dll_off_n), .q_i(q),
      .q_oe_n_i(q_oe_n), .valid_i(rvalid), .echo_true_i(echo_t));

   // Short lock count; static limit above the 4-cycle half period
   qsr_top #(.LOCK_EDGES(LOCK_N), .STATIC_CYC(6)) uut (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .k_i(k), .k_n_i(k_n),
      .read_sel_n_i(rd_n), .write_sel_n_i(wr_n), .addr_i(addr),
      .data_i(data), .byte_lane_strobe_n_i(strb), .dll_off_n_i(dll_off_n),
      .q_o(q), .q_oe_n_o(q_oe_n), .echo_clock_true_o(echo_t),
      .echo_clock_comp_o(echo_c), .read_valid_flag_o(rvalid),
      .dll_locked_o(locked), .buf_ready_o(buf_rdy));

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [17:0] seen,
                      input logic [17:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic timeout();
      num_errors++;
      $display("MISMATCH wait expected done seen hang");
      print_verdict();
   endtask

   task automatic wait_lock(input int start);
      int i;
      int d;
      for (i = 0; i < 400 && locked !== 1'b1; i++)
         @(posedge ref_clk_i);
      if (i == 400)
         timeout();
      d = ctrl.krise - start;
      chk("lock rises", 18'(d >= LOCK_N && d <= LOCK_N + 2), 18'h1);
   endtask

   task automatic xfer(input logic rd, input logic wr, input logic [5:0] a);
      int n;
      int i;
      for (n = 0; n < BURST; n++)
         for (int l = 0; l < 2; l++)
            if (wr && !ws[n][l])
               shadow[a][n][l*9 +: 9] = wd[n][l*9 +: 9];
      ctrl.rx_q.delete();
      ctrl.burst(rd, wr, a, wd, ws);
      for (i = 0; i < 100 && rd && ctrl.rx_q.size() < BURST; i++)
         @(posedge ref_clk_i);
      if (i == 100)
         timeout();
      for (n = 0; n < BURST && rd; n++)
         chk("read beat", ctrl.rx_q[n], shadow[a][n]);
      chk("rx beats", 18'(ctrl.rx_q.size()), 18'(rd ? BURST : 0));
      chk("buf ready", 18'(buf_rdy), 18'h1);
      chk("dll held", 18'(locked), 18'h1);
   endtask

   task automatic t_basic();
      wd = '{18'h2A5C3, 18'h15A3C, 18'h3F00F, 18'h00FF0};
      ws = '{2'h0, 2'h0, 2'h0, 2'h0};
      xfer(1'b0, 1'b1, 6'h05);
      xfer(1'b1, 1'b0, 6'h05);
      repeat (8) @(posedge ref_clk_i);
      chk("oe_n idle", 18'(q_oe_n), 18'h1);
      chk("valid idle", 18'(rvalid), 18'h0);
      chk("oe with beats", 18'(ctrl.oe_bad), 18'h0);
      $display("Test basic done");
   endtask

   task automatic t_strobe();
      wd = '{18'h11111, 18'h22222, 18'h33333, 18'h04444};
      ws = '{2'h1, 2'h2, 2'h3, 2'h0};
      xfer(1'b0, 1'b1, 6'h05);
      xfer(1'b1, 1'b0, 6'h05);
      $display("Test strobe done");
   endtask

   task automatic t_forward();
      wd = '{18'h3CCCC, 18'h0A0A0, 18'h35353, 18'h1E1E1};
      ws = '{2'h0, 2'h0, 2'h0, 2'h0};
      // Read shares the write's edge; only its first beat meets the forward copy, the rest come from the array
      xfer(1'b1, 1'b1, 6'h09);
      $display("Test forward done");
   endtask

   task automatic t_dll();
      ctrl.dll_disable();
      k0 = ctrl.krise;
      repeat (6) @(posedge ref_clk_i);
      chk("lock after off", 18'(locked), 18'h0);
      wait_lock(k0);
      ctrl.run <= 1'b0;
      repeat (14) @(posedge ref_clk_i);
      chk("lock after stop", 18'(locked), 18'h0);
      k0 = ctrl.krise;
      ctrl.run <= 1'b1;
      wait_lock(k0);
      xfer(1'b1, 1'b0, 6'h09);
      $display("Test dll done");
   endtask

   task automatic t_fifo();
      // Writes in a row pass the write buffer, then each is read back
      for (int a = 0; a < 4; a++)
      begin
         wd = '{18'(a), 18'(a + 16), 18'(a + 32), 18'(a + 48)};
         ws = '{2'h0, 2'h0, 2'h0, 2'h0};
         xfer(1'b0, 1'b1, 6'(a + 32));
         chk("fifo room", 18'(buf_rdy), 18'h1);
      end
      for (int a = 0; a < 4; a++)
         xfer(1'b1, 1'b0, 6'(a + 32));
      repeat (8) @(posedge ref_clk_i);
      chk("fifo oe idle", 18'(q_oe_n), 18'h1);
      chk("fifo valid idle", 18'(rvalid), 18'h0);
      chk("echo pair", 18'(echo_c), 18'(!echo_t));
      $display("Test fifo done");
   endtask

   initial
   begin
      repeat (6) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      k0 = ctrl.krise;
      @(posedge ref_clk_i);
      chk("reset oe_n", 18'(q_oe_n), 18'h1);
      chk("reset valid", 18'(rvalid), 18'h0);
      chk("reset lock", 18'(locked), 18'h0);
      wait_lock(k0);
      t_basic();
      t_strobe();
      t_forward();
      t_dll();
      t_fifo();
      print_verdict();
   end
endmodule // tb
